// [arpwm_consts.svh]
/*
  register offsets, field positions, reset values and timing counts of the
  auto-reload pwm timer. assumes an 8-bit register port with byte offsets.
*/
`ifndef ARPWM_CONSTS_SVH
`define ARPWM_CONSTS_SVH
`define ARPWM_A_CSR 6'h11
`define ARPWM_A_CNTH 6'h12
`define ARPWM_A_CNTL 6'h13
`define ARPWM_A_RLDH 6'h14
`define ARPWM_A_RLDL 6'h15
`define ARPWM_A_OEN 6'h16
`define ARPWM_A_CH0 6'h17
`define ARPWM_A_BRK1 6'h1B
`define ARPWM_A_BRK2 6'h1C
`define ARPWM_A_DC0 6'h1D
`define ARPWM_A_CAPH 6'h25
`define ARPWM_A_CAPL 6'h26
`define ARPWM_A_CFG 6'h27
`define ARPWM_CSR_ICF 6
`define ARPWM_CSR_CAPTURE_IRQ_ENABLE 5
`define ARPWM_CSR_OVF 2
`define ARPWM_CSR_OVIE 1
`define ARPWM_CSR_COMPARE_IRQ_ENABLE 0
`define ARPWM_CFG_RST 8'h03
`define ARPWM_TICK_NS 1000000
`define ARPWM_CLK_NS 4
`define ARPWM_TICK_CYC (`ARPWM_TICK_NS / `ARPWM_CLK_NS)
`define ARPWM_CNT_MAX 12'hFFF
`endif

// [arpwm_pkg.sv]
/*
  types of the auto-reload pwm timer. assumes nothing.
*/
package arpwm_pkg;
  typedef enum logic [1:0] {
    ARPWM_CK_OFF = 2'b00,
    ARPWM_CK_LITE = 2'b01,
    ARPWM_CK_CPU = 2'b10,
    ARPWM_CK_BAD = 2'b11
  } arpwm_ck_t;
endpackage : arpwm_pkg

// [arpwm_timer.sv]
/*
  12-bit auto-reload timer with four pwm outputs, two break channels and an
  input capture. assumes synchronous pins and a one-cycle-strobe byte port.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
// How it works
// RL1: capture flag set on capture, cleared by reading a capture byte, writes ignored.
// RL2: capture interrupt raised only while capture_irq_enable set.
// RL3: clock select 00 stop, 01 1 ms tick, 10 every cycle, 11 forbidden.
// RL4: overflow flag set on FFFh wrap, cleared by reading control status.
// RL5: overflow interrupt enable is a read/write bit cleared at reset.
// RL6: compare_irq_enable masks interrupt from any compare flag.
// RL7: 12-bit readable counter, zero at reset, counts when clocked.
// RL8: software reads low byte first; count is not latched.
// RL9: on overflow counter reloads from reload_value_1.
// RL10: output enable bit selects pwm drive or general purpose i/o.
// RL11: single_pulse_enable in channel three register only, clears on reset.
// RL12: single pulse edge on lite capture pin, falling 0, rising 1.
// RL13: polarity bit inverts its pwm output.
// RL14: compare flag set on counter equal duty, cleared by channel read.
// RL15: break one from pin or comparator; pin enable gates the pin.
// RL16: break one active level low when 0, high when 1.
// RL17: brk1_active set by active level, also software read/write.
// RL18: during break enabled outputs take the brk_pattern level.
// RL19: break two behaves the same with its own bits.
// RL20: with second counter, outputs two and three follow routed break.
// RL21: counter one break routing selects break one or two.
// RL22: duty value sets duty cycle and compare value.
// RL23: capture edge copies counter only while capture flag clear.
// RL24: capture source: main pin when 0, lite pin when 1.
// RL25: outputs two and three use second counter when selected.
// RL26: break applies per counter only while its enable set.
// RL27: interrupt requests follow flag and enable.
// RL28: reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`include "arpwm_consts.svh"
module arpwm_timer
  import arpwm_pkg::*;
#(
  parameter int TICK_CYC = `ARPWM_TICK_CYC,
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [11:0] second_upcounter,
  input wire logic capture_pin_main,
  input wire logic capture_pin_lite,
  input wire logic brk1_pin,
  input wire logic brk2_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe_n,
  output logic single_pulse_trig,
  output logic cap_irq,
  output logic ovf_irq,
  output logic cmp_irq
);
  if (NCH != 4 || TICK_CYC < 1) begin : g_bad_param
    $error("arpwm_timer: unsupported parameters");
  end

  logic capture_flag_q, capture_irq_enable_q, overflow_flag_1_q;
  logic overflow_irq_enable_1_q, compare_irq_enable_q;
  arpwm_ck_t ck_q;
  logic [11:0] main_upcounter_q, reload_value_1_q, captured_count_q;
  logic [3:0] oe_q, pol_q, cmpf_q, brk_pattern_q;
  logic [11:0] duty_q [4];
  logic single_pulse_enable_q, single_pulse_edge_q;
  logic brk1_source_select_q, brk1_active_level_q, brk1_active_q, brk1_pin_enable_q;
  logic brk2_source_select_q, brk2_active_level_q, brk2_active_q, brk2_pin_enable_q;
  logic brk_route_ctr1_q, brk_route_ctr2_q;
  logic brk_enable_ctr1_q, brk_enable_ctr2_q, second_counter_select_q, capture_source_select_q;
  logic [31:0] tick_cnt_q;
  logic cap_main_q, cap_lite_q;

  wire rd_csr = rd && addr == `ARPWM_A_CSR;
  wire rd_cap = rd && (addr == `ARPWM_A_CAPH || addr == `ARPWM_A_CAPL);
  wire wr_csr = wr && addr == `ARPWM_A_CSR;
  wire wr_brk1 = wr && addr == `ARPWM_A_BRK1;
  wire wr_brk2 = wr && addr == `ARPWM_A_BRK2;

  // counter tick selection
  logic tick;
  always_comb begin
    case (ck_q) // RL3
      ARPWM_CK_LITE: tick = (tick_cnt_q == 32'(TICK_CYC - 1));
      ARPWM_CK_CPU: tick = 1'b1;
      default: tick = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst || ck_q != ARPWM_CK_LITE || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'd1;
    end
  end

  wire ovf = tick && main_upcounter_q == `ARPWM_CNT_MAX;
  always_ff @(posedge clk) begin
    if (rst) begin
      main_upcounter_q <= '0;
    end else if (ovf) begin
      main_upcounter_q <= reload_value_1_q; // RL9
    end else if (tick) begin
      main_upcounter_q <= main_upcounter_q + 12'h001; // RL7
    end
  end

  // capture edges
  wire cap_sel_now = capture_source_select_q ? capture_pin_lite : capture_pin_main; // RL24
  wire cap_sel_old = capture_source_select_q ? cap_lite_q : cap_main_q;
  wire cap_edge = cap_sel_now != cap_sel_old;
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_main_q <= 1'b0;
      cap_lite_q <= 1'b0;
    end else begin
      cap_main_q <= capture_pin_main;
      cap_lite_q <= capture_pin_lite;
    end
  end
  wire do_cap = cap_edge && !capture_flag_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      captured_count_q <= '0;
    end else if (do_cap) begin
      captured_count_q <= main_upcounter_q; // RL23
    end
  end

  // control status register
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_flag_q <= 1'b0;
      overflow_flag_1_q <= 1'b0;
    end else begin
      capture_flag_q <= do_cap || (capture_flag_q && !rd_cap); // RL1
      overflow_flag_1_q <= ovf || (overflow_flag_1_q && !rd_csr); // RL4
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_irq_enable_q <= 1'b0;
      ck_q <= ARPWM_CK_OFF;
      overflow_irq_enable_1_q <= 1'b0;
      compare_irq_enable_q <= 1'b0;
    end else if (wr_csr) begin
      capture_irq_enable_q <= wdata[`ARPWM_CSR_CAPTURE_IRQ_ENABLE]; // RL2
      ck_q <= arpwm_ck_t'(wdata[4:3]); // RL3
      overflow_irq_enable_1_q <= wdata[`ARPWM_CSR_OVIE]; // RL5
      compare_irq_enable_q <= wdata[`ARPWM_CSR_COMPARE_IRQ_ENABLE]; // RL6
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload_value_1_q <= '0;
      oe_q <= '0;
      pol_q <= '0;
      single_pulse_enable_q <= 1'b0;
      single_pulse_edge_q <= 1'b0;
      brk_enable_ctr1_q <= 1'b1;
      brk_enable_ctr2_q <= 1'b1;
      second_counter_select_q <= 1'b0;
      capture_source_select_q <= 1'b0;
    end else if (wr) begin
      if (addr == `ARPWM_A_RLDH) begin
        reload_value_1_q[11:8] <= wdata[3:0];
      end else if (addr == `ARPWM_A_RLDL) begin
        reload_value_1_q[7:0] <= wdata;
      end else if (addr == `ARPWM_A_OEN) begin
        oe_q <= {wdata[6], wdata[4], wdata[2], wdata[0]}; // RL10
      end else if (addr >= `ARPWM_A_CH0 && addr < `ARPWM_A_CH0 + 6'd4) begin
        pol_q[2'(addr - `ARPWM_A_CH0)] <= wdata[1]; // RL13
        if (addr == `ARPWM_A_CH0 + 6'd3) begin
          single_pulse_enable_q <= wdata[3]; // RL11
          single_pulse_edge_q <= wdata[2];
        end
      end else if (addr == `ARPWM_A_CFG) begin
        brk_enable_ctr1_q <= wdata[0];
        brk_enable_ctr2_q <= wdata[1];
        second_counter_select_q <= wdata[2];
        capture_source_select_q <= wdata[5];
      end
    end
  end

  // duty values and compare flags, one per channel
  logic [3:0] ch_rd;
  for (genvar i = 0; i < 4; i++) begin : g_ch
    wire [11:0] cnt_src = (i >= 2 && second_counter_select_q) ? second_upcounter
                                                               : main_upcounter_q; // RL25
    wire match = cnt_src == duty_q[i];
    assign ch_rd[i] = rd && addr == `ARPWM_A_CH0 + 6'(i);
    always_ff @(posedge clk) begin
      if (rst) begin
        duty_q[i] <= '0;
      end else if (wr && addr == `ARPWM_A_DC0 + 6'(2 * i)) begin
        duty_q[i][11:8] <= wdata[3:0]; // RL22
      end else if (wr && addr == `ARPWM_A_DC0 + 6'(2 * i + 1)) begin
        duty_q[i][7:0] <= wdata;
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        cmpf_q[i] <= 1'b0;
      end else begin
        cmpf_q[i] <= match || (cmpf_q[i] && !ch_rd[i]); // RL14
      end
    end
  end

  // break channels
  wire brk1_src = brk1_source_select_q ? cmp1_out : (brk1_pin && brk1_pin_enable_q); // RL15
  wire brk2_src = brk2_source_select_q ? cmp2_out : (brk2_pin && brk2_pin_enable_q); // RL19
  wire brk1_hit = (brk1_source_select_q || brk1_pin_enable_q)
                  && (brk1_active_level_q ? brk1_src : !brk1_src); // RL16
  wire brk2_hit = (brk2_source_select_q || brk2_pin_enable_q)
                  && (brk2_active_level_q ? brk2_src : !brk2_src); // RL19
  always_ff @(posedge clk) begin
    if (rst) begin
      brk1_source_select_q <= 1'b0;
      brk1_active_level_q <= 1'b0;
      brk1_active_q <= 1'b0;
      brk1_pin_enable_q <= 1'b0;
      brk_pattern_q <= '0;
    end else begin
      if (wr_brk1) begin
        brk1_source_select_q <= wdata[7];
        brk1_active_level_q <= wdata[6];
        brk1_pin_enable_q <= wdata[4];
        brk_pattern_q <= wdata[3:0]; // RL18
      end
      brk1_active_q <= brk1_hit || (wr_brk1 ? wdata[5] : brk1_active_q); // RL17
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      brk2_source_select_q <= 1'b0;
      brk2_active_level_q <= 1'b0;
      brk2_active_q <= 1'b0;
      brk2_pin_enable_q <= 1'b0;
      brk_route_ctr1_q <= 1'b0;
      brk_route_ctr2_q <= 1'b0;
    end else begin
      if (wr_brk2) begin
        brk2_source_select_q <= wdata[7];
        brk2_active_level_q <= wdata[6];
        brk2_pin_enable_q <= wdata[4];
        brk_route_ctr2_q <= wdata[1];
        brk_route_ctr1_q <= wdata[0];
      end
      brk2_active_q <= brk2_hit || (wr_brk2 ? wdata[5] : brk2_active_q); // RL19
    end
  end

  wire brk_c1 = brk_enable_ctr1_q && (brk_route_ctr1_q ? brk2_active_q : brk1_active_q); // RL21
  wire brk_c2 = brk_enable_ctr2_q && (brk_route_ctr2_q ? brk2_active_q : brk1_active_q); // RL20
  wire brk_hi = second_counter_select_q ? brk_c2 : brk_c1; // RL26
  wire [3:0] brk_vec = {brk_hi, brk_hi, brk_c1, brk_c1};

  // pwm outputs
  for (genvar j = 0; j < 4; j++) begin : g_pwm
    wire [11:0] cnt_src = (j >= 2 && second_counter_select_q) ? second_upcounter
                                                               : main_upcounter_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        pwm_out[j] <= 1'b0;
        pwm_oe_n[j] <= 1'b1;
      end else begin
        pwm_oe_n[j] <= !oe_q[j]; // RL10
        pwm_out[j] <= (oe_q[j] && brk_vec[j]) ? brk_pattern_q[j]
                                               : (cnt_src < duty_q[j]) ^ pol_q[j]; // RL18 RL13
      end
    end
  end

  // single pulse trigger edge
  always_ff @(posedge clk) begin
    if (rst) begin
      single_pulse_trig <= 1'b0;
    end else begin
      single_pulse_trig <= single_pulse_enable_q && (capture_pin_lite != cap_lite_q)
                           && (capture_pin_lite == single_pulse_edge_q); // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_irq <= 1'b0;
      ovf_irq <= 1'b0;
      cmp_irq <= 1'b0;
    end else begin
      cap_irq <= capture_flag_q && capture_irq_enable_q; // RL27 RL2
      ovf_irq <= overflow_flag_1_q && overflow_irq_enable_1_q; // RL27
      cmp_irq <= (|cmpf_q) && compare_irq_enable_q; // RL6
    end
  end

  // read port, reserved bits zero
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata <= '0;
    end else if (addr == `ARPWM_A_CSR) begin
      rdata <= {1'b0, capture_flag_q, capture_irq_enable_q, ck_q, overflow_flag_1_q,
                overflow_irq_enable_1_q, compare_irq_enable_q}; // RL28
    end else if (addr == `ARPWM_A_CNTH) begin
      rdata <= {4'h0, main_upcounter_q[11:8]}; // RL8
    end else if (addr == `ARPWM_A_CNTL) begin
      rdata <= main_upcounter_q[7:0];
    end else if (addr == `ARPWM_A_RLDH) begin
      rdata <= {4'h0, reload_value_1_q[11:8]};
    end else if (addr == `ARPWM_A_RLDL) begin
      rdata <= reload_value_1_q[7:0];
    end else if (addr == `ARPWM_A_OEN) begin
      rdata <= {1'b0, oe_q[3], 1'b0, oe_q[2], 1'b0, oe_q[1], 1'b0, oe_q[0]};
    end else if (addr >= `ARPWM_A_CH0 && addr < `ARPWM_A_CH0 + 6'd4) begin
      rdata <= {4'h0, (addr == `ARPWM_A_CH0 + 6'd3) ? single_pulse_enable_q : 1'b0,
                (addr == `ARPWM_A_CH0 + 6'd3) ? single_pulse_edge_q : 1'b0,
                pol_q[2'(addr - `ARPWM_A_CH0)], cmpf_q[2'(addr - `ARPWM_A_CH0)]};
    end else if (addr == `ARPWM_A_BRK1) begin
      rdata <= {brk1_source_select_q, brk1_active_level_q, brk1_active_q, brk1_pin_enable_q,
                brk_pattern_q};
    end else if (addr == `ARPWM_A_BRK2) begin
      rdata <= {brk2_source_select_q, brk2_active_level_q, brk2_active_q, brk2_pin_enable_q,
                2'b00, brk_route_ctr2_q, brk_route_ctr1_q};
    end else if (addr >= `ARPWM_A_DC0 && addr < `ARPWM_A_DC0 + 6'd8) begin
      rdata <= addr[0] ? {4'h0, duty_q[2'((addr - `ARPWM_A_DC0) >> 1)][11:8]}
                       : duty_q[2'((addr - `ARPWM_A_DC0) >> 1)][7:0];
    end else if (addr == `ARPWM_A_CAPH) begin
      rdata <= {4'h0, captured_count_q[11:8]};
    end else if (addr == `ARPWM_A_CAPL) begin
      rdata <= captured_count_q[7:0];
    end else if (addr == `ARPWM_A_CFG) begin
      rdata <= {2'b00, capture_source_select_q, 2'b00, second_counter_select_q,
                brk_enable_ctr2_q, brk_enable_ctr1_q};
    end else begin
      rdata <= '0;
    end
  end

  property p_cap_clear;
    @(posedge clk) disable iff (rst) rd_cap && !do_cap |=> !capture_flag_q;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture flag not cleared"); // RL1
  property p_cap_irq;
    @(posedge clk) disable iff (rst) !capture_irq_enable_q |=> !cap_irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq while disabled"); // RL2
  property p_stop;
    @(posedge clk) disable iff (rst) ck_q == ARPWM_CK_OFF |=> $stable(main_upcounter_q);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped"); // RL3
  property p_ovf;
    @(posedge clk) disable iff (rst)
      ck_q == ARPWM_CK_CPU && main_upcounter_q == 12'hFFF
      |=> overflow_flag_1_q && main_upcounter_q == $past(reload_value_1_q);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow reload wrong"); // RL4
  property p_inc;
    @(posedge clk) disable iff (rst)
      ck_q == ARPWM_CK_CPU && main_upcounter_q != 12'hFFF
      |=> main_upcounter_q == $past(main_upcounter_q) + 12'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not increment"); // RL7
  property p_cap_hold;
    @(posedge clk) disable iff (rst) capture_flag_q |=> $stable(captured_count_q);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture overwritten"); // RL23
  property p_oe;
    @(posedge clk) disable iff (rst) ##1 pwm_oe_n == ~$past(oe_q);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong"); // RL10
  property p_brk;
    @(posedge clk) disable iff (rst) oe_q[0] && brk_c1 |=> pwm_out[0] == $past(brk_pattern_q[0]);
  endproperty
  a_brk: assert property (p_brk) else $error("break pattern not applied"); // RL18
  property p_cmp;
    @(posedge clk) disable iff (rst) !second_counter_select_q && main_upcounter_q == duty_q[0]
      |=> cmpf_q[0];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag missed"); // RL14
  c_ovf: cover property (@(posedge clk) disable iff (rst) ovf);
  c_cap: cover property (@(posedge clk) disable iff (rst) do_cap);
  c_brk: cover property (@(posedge clk) disable iff (rst) brk1_active_q && oe_q[0]);
endmodule : arpwm_timer

// [arpwm_pins.sv]
/*
  pin-side model: capture, break and comparator sources, resolved pwm pads.
  assumes released pads are pulled up and break pins idle high.
*/
`timescale 1ns/100ps
module arpwm_pins (
  input wire logic clk,
  input wire logic [3:0] pwm_out,
  input wire logic [3:0] pwm_oe_n,
  output logic [3:0] pad,
  output logic cap_main,
  output logic cap_lite,
  output logic brk1,
  output logic brk2,
  output logic cmp1,
  output logic cmp2
);
  // released pads float up to the pull-up
  assign pad = (pwm_out & ~pwm_oe_n) | pwm_oe_n;
  initial begin
    {cap_main, cap_lite, cmp1, cmp2} = 4'h0;
    {brk1, brk2} = 2'h3;
  end
  // bits: cap_main, cap_lite, brk1, brk2, cmp1, cmp2
  task automatic drive(input logic [5:0] v);
    @(posedge clk);
    {cap_main, cap_lite, brk1, brk2, cmp1, cmp2} <= v;
  endtask : drive
endmodule : arpwm_pins

// [tb_arpwm_timer.sv]
/*
  self-checking bench of the auto-reload pwm timer through its byte port.
  assumes arpwm_pins as pin partner and a short lite tick of 4 cycles.
*/
`timescale 1ns/100ps
`include "arpwm_consts.svh"
module tb_arpwm_timer
  import arpwm_pkg::*;
;
  logic clk, rst, wr, rd;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, d, e;
  logic [3:0] pwm_out, pwm_oe_n, pad;
  logic cm, cl, b1, b2, c1, c2, trig, cap_irq, ovf_irq, cmp_irq;
  logic [11:0] c, sec;
  int err_total = 0;
  int total_checks = 0;
  int trig_n = 0;
  arpwm_timer #(.TICK_CYC(4)) DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .second_upcounter(sec), .capture_pin_main(cm),
    .capture_pin_lite(cl), .brk1_pin(b1), .brk2_pin(b2), .cmp1_out(c1), .cmp2_out(c2),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .single_pulse_trig(trig),
    .cap_irq(cap_irq), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq));
  arpwm_pins PINS (.clk(clk), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .pad(pad),
    .cap_main(cm), .cap_lite(cl), .brk1(b1), .brk2(b2), .cmp1(c1), .cmp2(c2));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (trig === 1'b1) trig_n++;
  function automatic logic [7:0] csr(logic ie, arpwm_ck_t ck, logic ov, logic cp);
    return {2'h0, ie, ck, 1'h0, ov, cp};
  endfunction : csr
  task automatic wreg(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic hi_cnt(input int n, output logic [11:0] k);
    k = 12'h000;
    repeat (n) begin
      @(posedge clk);
      #1 if (pad[0] === 1'b1) k++;
    end
  endtask : hi_cnt
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic t_reset;
    rreg(`ARPWM_A_CSR, d); chk(d, 12'h000, "csr reset");
    rreg(`ARPWM_A_CFG, d); chk(d, `ARPWM_CFG_RST, "cfg reset");
    chk(pwm_oe_n, 12'h00F, "pads released");
    wreg(6'h00, 8'hFF); rreg(6'h00, d); chk(d, 12'h000, "unmapped");
    wreg(`ARPWM_A_CSR, 8'hFF); rreg(`ARPWM_A_CSR, d); chk(d, 12'h03B, "csr write");
    rreg(`ARPWM_A_CNTL, d); chk(d, 12'h000, "forbidden clock stops");
    $display("test reset done");
  endtask : t_reset
  task automatic t_count;
    wreg(`ARPWM_A_RLDH, 8'h0F); wreg(`ARPWM_A_RLDL, 8'hF0);
    rreg(`ARPWM_A_RLDH, d); chk(d, 12'h00F, "reload high");
    wreg(`ARPWM_A_CSR, csr(1'b0, ARPWM_CK_CPU, 1'b1, 1'b0));
    repeat (4200) @(posedge clk);
    rreg(`ARPWM_A_CNTL, d); rreg(`ARPWM_A_CNTH, e);
    chk(e, 12'h00F, "count high after reload");
    chk(d[7:4], 12'h00F, "count low after reload");
    chk(ovf_irq, 12'h001, "overflow irq");
    wreg(`ARPWM_A_CSR, csr(1'b0, ARPWM_CK_OFF, 1'b1, 1'b0));
    rreg(`ARPWM_A_CSR, d); chk(d, 12'h006, "overflow flag");
    rreg(`ARPWM_A_CSR, d); chk(d, 12'h002, "overflow cleared by read");
    repeat (2) @(posedge clk);
    #1 chk(ovf_irq, 12'h000, "overflow irq dropped");
    rreg(`ARPWM_A_CNTL, d); rreg(`ARPWM_A_CNTL, e); chk(e, d, "stopped");
    wreg(`ARPWM_A_CSR, csr(1'b0, ARPWM_CK_LITE, 1'b0, 1'b0));
    rreg(`ARPWM_A_CNTL, d);
    repeat (40) @(posedge clk);
    rreg(`ARPWM_A_CNTL, e);
    c = {4'h0, (e - d) & 8'h0F};
    chk((c >= 12'h00A) && (c <= 12'h00B), 12'h001, "lite tick rate");
    $display("test count done");
  endtask : t_count
  task automatic t_pwm;
    wreg(`ARPWM_A_DC0, 8'h0F); wreg(`ARPWM_A_DC0 + 6'h01, 8'hF4);
    wreg(`ARPWM_A_OEN, 8'h01);
    wreg(`ARPWM_A_CSR, csr(1'b0, ARPWM_CK_CPU, 1'b0, 1'b1));
    repeat (4) @(posedge clk);
    #1 chk(pwm_oe_n, 12'h00E, "only pad 0 driven");
    hi_cnt(32, c); chk(c, 12'h008, "duty highs");
    chk(cmp_irq, 12'h001, "compare irq");
    rreg(`ARPWM_A_CH0, d); chk(d[0], 12'h001, "compare flag");
    wreg(`ARPWM_A_CH0, 8'h02);
    repeat (4) @(posedge clk);
    hi_cnt(32, c); chk(c, 12'h018, "inverted highs");
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_break;
    wreg(`ARPWM_A_BRK1, 8'h11);
    PINS.drive(6'h04);
    repeat (4) @(posedge clk);
    hi_cnt(16, c); chk(c, 12'h010, "break one pattern");
    rreg(`ARPWM_A_BRK1, d); chk(d, 12'h031, "break one active");
    PINS.drive(6'h0C);
    wreg(`ARPWM_A_BRK1, 8'h10);
    repeat (4) @(posedge clk);
    hi_cnt(32, c); chk(c, 12'h018, "break one off");
    wreg(`ARPWM_A_BRK2, 8'hC1);
    PINS.drive(6'h0D);
    wreg(`ARPWM_A_BRK1, 8'h01);
    repeat (4) @(posedge clk);
    hi_cnt(16, c); chk(c, 12'h010, "break two routed");
    rreg(`ARPWM_A_BRK2, d); chk(d, 12'h0E1, "break two active");
    wreg(`ARPWM_A_CFG, 8'h02);
    repeat (4) @(posedge clk);
    hi_cnt(32, c); chk(c, 12'h018, "break gated off");
    PINS.drive(6'h0C);
    wreg(`ARPWM_A_BRK2, 8'h00); wreg(`ARPWM_A_BRK1, 8'h00); wreg(`ARPWM_A_CFG, 8'h03);
    $display("test break done");
  endtask : t_break
  task automatic t_capture;
    wreg(`ARPWM_A_CSR, csr(1'b1, ARPWM_CK_OFF, 1'b0, 1'b0));
    rreg(`ARPWM_A_CNTL, d);
    PINS.drive(6'h2C);
    repeat (4) @(posedge clk);
    #1 chk(cap_irq, 12'h001, "capture irq");
    wreg(`ARPWM_A_CSR, csr(1'b1, ARPWM_CK_CPU, 1'b0, 1'b0));
    wreg(`ARPWM_A_CSR, csr(1'b1, ARPWM_CK_OFF, 1'b0, 1'b0));
    rreg(`ARPWM_A_CNTL, e); chk(e !== d, 12'h001, "counter moved");
    PINS.drive(6'h0C);
    repeat (4) @(posedge clk);
    rreg(`ARPWM_A_CAPL, e); chk(e, d, "first capture kept");
    rreg(`ARPWM_A_CSR, e); chk(e[6], 12'h000, "capture flag cleared");
    chk(cap_irq, 12'h000, "capture irq dropped");
    wreg(`ARPWM_A_CSR, csr(1'b0, ARPWM_CK_OFF, 1'b0, 1'b0));
    wreg(`ARPWM_A_CFG, 8'h23); wreg(`ARPWM_A_CH0 + 6'h03, 8'h0C);
    trig_n = 0;
    PINS.drive(6'h1C);
    repeat (4) @(posedge clk);
    #1 chk(12'(trig_n), 12'h001, "rising pulse trigger");
    chk(cap_irq, 12'h000, "capture irq masked");
    rreg(`ARPWM_A_CSR, e); chk(e[6], 12'h001, "lite capture");
    PINS.drive(6'h0C);
    repeat (4) @(posedge clk);
    #1 chk(12'(trig_n), 12'h001, "falling edge ignored");
    rreg(`ARPWM_A_CAPH, e); chk(e, 12'h00F, "lite capture high");
    $display("test capture done");
  endtask : t_capture
  task automatic t_second;
    wreg(`ARPWM_A_DC0 + 6'h04, 8'h08); wreg(`ARPWM_A_DC0 + 6'h05, 8'h00);
    wreg(`ARPWM_A_OEN, 8'h10);
    wreg(`ARPWM_A_CFG, 8'h07);
    repeat (2) @(posedge clk);
    #1 chk(pad[2], 12'h001, "ch2 follows second counter");
    @(posedge clk);
    sec <= 12'h900;
    repeat (2) @(posedge clk);
    #1 chk(pad[2], 12'h000, "ch2 second counter above duty");
    @(posedge clk);
    sec <= 12'h100;
    wreg(`ARPWM_A_CFG, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk(pad[2], 12'h000, "ch2 back on main counter");
    wreg(`ARPWM_A_CFG, 8'h06);
    wreg(`ARPWM_A_BRK2, 8'h22);
    repeat (2) @(posedge clk);
    #1 chk(pad[2], 12'h000, "ch2 break two routed");
    wreg(`ARPWM_A_BRK2, 8'h20);
    repeat (2) @(posedge clk);
    #1 chk(pad[2], 12'h001, "ch2 break one idle");
    wreg(`ARPWM_A_BRK1, 8'hC0);
    PINS.drive(6'h0E);
    repeat (3) @(posedge clk);
    #1 chk(pad[2], 12'h000, "break one from comparator");
    PINS.drive(6'h0C);
    $display("test second counter done");
  endtask : t_second
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test;
  end
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 6'h00; wdata = 8'h00;
    sec = 12'h100;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_count;
    t_pwm;
    t_break;
    t_capture;
    t_second;
    finish_test;
  end
endmodule : tb_arpwm_timer
